// ===== bmd_decoder.sv
// memory and i/o decoder with wait-state generation and dual-port arbitration
// Functional notes
// - two independent local socket pairs, each its own address region
// - boot pair always holds the highest local addresses
// - local memory is cpu only; dual-port is reachable by cpu and bus masters
// - decode caps local at 256K bytes and dual-port at 128K bytes
// - dual-port appears as an independent byte-wide resource to both sides
// - simultaneous dual-port request: on-board cpu is granted first
// - default two waits for dual-port, one wait for local sockets
// - local wait count is a configurable setting
// - expansion-module i/o cycles get at least 2 wait states
// - active-low module wait request stretches the cycle while asserted
// - ports 0080h-00bfh go to modules if fitted, else system-bus i/o
// - default: off-board local cycles go over the local bus extension, 14 mb
// - synchronous interface mode: off-board cycles complete with no waits
`timescale 1ns/100ps
module bmd_decoder (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration straps
    input wire logic [3:0] cfg_local_waits,
    input wire logic [23:0] cfg_boot_size,
    input wire logic [23:0] cfg_dual_base,
    input wire logic cfg_modules_present,
    input wire logic cfg_sync_mode,
    // on-board cpu
    input wire bmd_pkg::bmd_cpu_req_t cpu_req,
    output logic cpu_ready,
    // target selects
    output bmd_pkg::bmd_sel_t sel,
    output bmd_pkg::bmd_target_t target,
    // expansion module wait request, from a pin
    input wire logic module_wait_request_n,
    // external bus master dual-port port
    input wire logic ext_dual_req,
    input wire logic [16:0] ext_dual_addr,
    input wire logic ext_bus_owned,
    output logic ext_dual_grant,
    output logic [16:0] dual_addr
);

    // counted waits, then one cycle of ready, then back to idle
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } bmd_state_t;

    ////////////////////////////////////////////////////////////////////////
    // decode
    // offset is one bit wider so a region ending at the top of memory cannot wrap
    function automatic logic in_range(input logic [23:0] a, input logic [23:0] base,
                                      input logic [23:0] size);
        logic [24:0] off;
        off = {1'b0, a} - {1'b0, base};
        in_range = (a >= base) && (off < {1'b0, size});
    endfunction

    function automatic bmd_pkg::bmd_target_t decode(input bmd_pkg::bmd_cpu_req_t r,
                                                    input logic mods,
                                                    input logic [23:0] boot_size,
                                                    input logic [23:0] dual_base);
        logic [23:0] boot_base;
        boot_base = bmd_pkg::LOCAL_TOP - boot_size + 24'h000001;
        // i/o space first, then memory in order boot, user, dual, extension, bus
        if (r.is_io)
        begin
            if (r.addr[15:0] >= bmd_pkg::MOD_IO_LO && r.addr[15:0] <= bmd_pkg::MOD_IO_HI
                && mods)
                decode = bmd_pkg::BMD_TGT_MOD;
            else
                decode = bmd_pkg::BMD_TGT_BUS;
        end
        else if (in_range(r.addr, boot_base, boot_size))
            decode = bmd_pkg::BMD_TGT_BOOT;
        else if (in_range(r.addr, bmd_pkg::LOCAL_BASE, bmd_pkg::LOCAL_SIZE))
            decode = bmd_pkg::BMD_TGT_USER;
        else if (in_range(r.addr, dual_base, bmd_pkg::DUAL_SIZE))
            decode = bmd_pkg::BMD_TGT_DUAL;
        else if (in_range(r.addr, bmd_pkg::EXT_BASE, bmd_pkg::EXT_SIZE))
            decode = bmd_pkg::BMD_TGT_EXT;
        else
            decode = bmd_pkg::BMD_TGT_BUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration capture after reset release
    // straps are taken once, so a moved jumper never remaps a cycle in flight
    logic [3:0] local_waits_q, local_waits_d;
    logic [23:0] boot_size_q, boot_size_d;
    logic [23:0] dual_base_q, dual_base_d;
    logic mods_q, mods_d;
    logic sync_mode_q, sync_mode_d;
    logic cfg_taken_q, cfg_taken_d;

    always_comb
    begin
        local_waits_d = local_waits_q;
        boot_size_d = boot_size_q;
        dual_base_d = dual_base_q;
        mods_d = mods_q;
        sync_mode_d = sync_mode_q;
        cfg_taken_d = 1'b1;
        if (!cfg_taken_q)
        begin
            local_waits_d = cfg_local_waits;
            // boot pair cannot exceed the local region
            if (cfg_boot_size > bmd_pkg::LOCAL_SIZE || cfg_boot_size == 24'h000000)
                boot_size_d = bmd_pkg::BOOT_SIZE_RST;
            else
                boot_size_d = cfg_boot_size;
            // force a 128K boundary so the low 17 bits index the array
            dual_base_d = cfg_dual_base & ~(bmd_pkg::DUAL_SIZE - 24'h000001);
            mods_d = cfg_modules_present;
            sync_mode_d = cfg_sync_mode;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // the local count keeps its default until the straps are taken
            local_waits_q <= bmd_pkg::WAIT_LOCAL_RST;
            boot_size_q <= bmd_pkg::BOOT_SIZE_RST;
            dual_base_q <= bmd_pkg::DUAL_BASE_RST;
            mods_q <= 1'b0;
            sync_mode_q <= 1'b0;
            cfg_taken_q <= 1'b0;
        end
        else
        begin
            local_waits_q <= local_waits_d;
            boot_size_q <= boot_size_d;
            dual_base_q <= dual_base_d;
            mods_q <= mods_d;
            sync_mode_q <= sync_mode_d;
            cfg_taken_q <= cfg_taken_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // module wait request synchroniser
    // the pin comes from a module with its own timing, hence three stages
    logic [2:0] mw_sync_q, mw_sync_d;
    logic mw_active_q, mw_active_d;

    always_comb
    begin
        mw_sync_d = {mw_sync_q[1:0], ~module_wait_request_n};
        mw_active_d = mw_active_q;
        // hold the last agreed level while stages 2 and 3 differ
        if (mw_sync_q[1] == mw_sync_q[2])
            mw_active_d = mw_sync_q[2];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mw_sync_q <= 3'h0;
            mw_active_q <= 1'b0;
        end
        else
        begin
            mw_sync_q <= mw_sync_d;
            mw_active_q <= mw_active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle state machine and dual-port arbitration
    bmd_state_t state_q, state_d;
    bmd_pkg::bmd_target_t tgt_q, tgt_d;
    logic [3:0] wait_q, wait_d;
    logic ext_grant_q, ext_grant_d;
    logic [16:0] dual_addr_q, dual_addr_d;
    bmd_pkg::bmd_target_t dec;
    logic [3:0] waits_for;
    logic cpu_dual_busy;

    always_comb
    begin
        dec = decode(cpu_req, mods_q, boot_size_q, dual_base_q);
        // the extension uses the local count unless it runs in sync mode
        case (dec)
            bmd_pkg::BMD_TGT_BOOT,
            bmd_pkg::BMD_TGT_USER: waits_for = local_waits_q;
            bmd_pkg::BMD_TGT_DUAL: waits_for = bmd_pkg::WAIT_DUAL;
            bmd_pkg::BMD_TGT_MOD: waits_for = bmd_pkg::WAIT_MOD_MIN;
            bmd_pkg::BMD_TGT_EXT: waits_for = sync_mode_q ? bmd_pkg::WAIT_SYNC
                                                           : local_waits_q;
            default: waits_for = bmd_pkg::WAIT_NONE;
        endcase
    end

    // cpu holds the dual-port while it starts or runs a dual-port cycle
    assign cpu_dual_busy = (state_q == ST_IDLE && cpu_req.start && !cpu_req.is_io
                            && dec == bmd_pkg::BMD_TGT_DUAL)
                           || (state_q != ST_IDLE && tgt_q == bmd_pkg::BMD_TGT_DUAL);

    always_comb
    begin
        state_d = state_q;
        tgt_d = tgt_q;
        wait_d = wait_q;
        dual_addr_d = dual_addr_q;
        case (state_q)
            ST_IDLE:
            begin
                // start is seen only here; a start during a cycle is dropped
                tgt_d = bmd_pkg::BMD_TGT_NONE;
                if (cpu_req.start)
                begin
                    tgt_d = dec;
                    wait_d = waits_for;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // only module cycles stretch; the agreed level is used at once so a
                // wait raised at cycle start lands before the minimum count runs out
                if (wait_q != 4'h0)
                    wait_d = wait_q - 4'h1;
                else if (!(tgt_q == bmd_pkg::BMD_TGT_MOD && mw_active_d))
                    state_d = ST_DONE;
            end
            ST_DONE:
            begin
                // ready stands this one cycle; the next start is taken in idle
                tgt_d = bmd_pkg::BMD_TGT_NONE;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // external master only while it owns the system bus and cpu is off
        ext_grant_d = ext_dual_req && ext_bus_owned && !cpu_dual_busy;
        // the cpu takes the array address only for its own dual-port cycles, so
        // other cycles leave a granted master's address in place
        if (state_q == ST_IDLE && cpu_dual_busy)
            dual_addr_d = cpu_req.addr[16:0];
        else if (ext_grant_d)
            dual_addr_d = ext_dual_addr;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            tgt_q <= bmd_pkg::BMD_TGT_NONE;
            wait_q <= 4'h0;
            ext_grant_q <= 1'b0;
            dual_addr_q <= 17'h00000;
        end
        else
        begin
            state_q <= state_d;
            tgt_q <= tgt_d;
            wait_q <= wait_d;
            ext_grant_q <= ext_grant_d;
            dual_addr_q <= dual_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chip selects, registered so that decode glitches never reach a device
    bmd_pkg::bmd_sel_t sel_q, sel_d;

    always_comb
    begin
        sel_d.boot_sel = (tgt_d == bmd_pkg::BMD_TGT_BOOT);
        sel_d.user_sel = (tgt_d == bmd_pkg::BMD_TGT_USER);
        // an external grant also opens the array
        sel_d.dual_sel = (tgt_d == bmd_pkg::BMD_TGT_DUAL) || ext_grant_d;
        sel_d.ext_sel = (tgt_d == bmd_pkg::BMD_TGT_EXT);
        sel_d.mod_sel = (tgt_d == bmd_pkg::BMD_TGT_MOD);
        sel_d.bus_sel = (tgt_d == bmd_pkg::BMD_TGT_BUS);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            sel_q <= '0;
        else
            sel_q <= sel_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // ready is a one-cycle pulse straight from the state register
    assign cpu_ready = (state_q == ST_DONE);
    assign target = tgt_q;
    assign ext_dual_grant = ext_grant_q;
    assign dual_addr = dual_addr_q;
    assign sel = sel_q;

endmodule // bmd_decoder

// ===== bmd_decoder_bench.sv
// self-checking bench for the memory and i/o decoder
`timescale 1ns/100ps
module bmd_decoder_bench;
    typedef struct {logic io; logic [23:0] a; bmd_pkg::bmd_target_t t; int w;} bmd_row_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] cfg_local_waits = 4'h1;
    logic [23:0] cfg_boot_size = 24'h008000;
    logic [23:0] cfg_dual_base = 24'h000000;
    logic cfg_modules_present = 1'b1;
    logic cfg_sync_mode = 1'b0;
    bmd_pkg::bmd_cpu_req_t cpu_req = '0;
    logic module_wait_request_n = 1'b1;
    logic go = 1'b0;
    logic skip_arb = 1'b0;
    logic [16:0] ext_addr = 17'h00000;
    logic cpu_ready, ext_dual_grant, ext_bus_owned, ext_dual_req;
    logic [16:0] ext_dual_addr, dual_addr;
    bmd_pkg::bmd_sel_t sel;
    bmd_pkg::bmd_target_t target;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    bmd_row_t rows [13] = '{'{1'b0, 24'hffff00, bmd_pkg::BMD_TGT_BOOT, 1},
        '{1'b0, 24'hff7fff, bmd_pkg::BMD_TGT_USER, 1}, '{1'b0, 24'hfc0000, bmd_pkg::BMD_TGT_USER, 1},
        '{1'b0, 24'h000010, bmd_pkg::BMD_TGT_DUAL, 2}, '{1'b0, 24'h01ffff, bmd_pkg::BMD_TGT_DUAL, 2},
        '{1'b0, 24'h020000, bmd_pkg::BMD_TGT_BUS, 0}, '{1'b0, 24'h100000, bmd_pkg::BMD_TGT_EXT, 1},
        '{1'b0, 24'hefffff, bmd_pkg::BMD_TGT_EXT, 1}, '{1'b0, 24'hf00000, bmd_pkg::BMD_TGT_BUS, 0},
        '{1'b1, 24'h000080, bmd_pkg::BMD_TGT_MOD, 2}, '{1'b1, 24'h0000bf, bmd_pkg::BMD_TGT_MOD, 2},
        '{1'b1, 24'h0000c0, bmd_pkg::BMD_TGT_BUS, 0}, '{1'b1, 24'h00007f, bmd_pkg::BMD_TGT_BUS, 0}};
    bmd_decoder u_dut (.sys_clk, .reset_n, .cfg_local_waits, .cfg_boot_size,
        .cfg_dual_base, .cfg_modules_present, .cfg_sync_mode, .cpu_req, .cpu_ready,
        .sel, .target, .module_wait_request_n, .ext_dual_req, .ext_dual_addr, .ext_bus_owned,
        .ext_dual_grant, .dual_addr);
    bmd_ext_master u_ext (.sys_clk, .reset_n, .go, .skip_arb, .addr(ext_addr), .ext_bus_owned,
        .ext_dual_req, .ext_dual_addr);
    always #5 sys_clk = ~sys_clk;
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one cpu cycle; hold keeps the module wait pin low for that many cycles
    task automatic run(input logic io, input logic [23:0] a, input bmd_pkg::bmd_target_t t,
        input int w, input int hold);
        int n;
        @(posedge sys_clk);
        cpu_req <= '{1'b1, io, a};
        module_wait_request_n <= (hold == 0);
        @(posedge sys_clk);
        cpu_req.start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            if (n + 1 == hold)
                module_wait_request_n <= 1'b1;
            #1 n++;
            if (n == 1)
                check(sel, 6'h20 >> (t - 1));
            if (n == 1)
                check(target, t);
        end while (cpu_ready !== 1'b1 && n < 40);
        if (hold == 0)
            check(n, w + 1);
        else
            check(n >= hold && n <= hold + 8, 1'b1);
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        foreach (rows[i])
            run(rows[i].io, rows[i].a, rows[i].t, rows[i].w, 0);
        $display("test decode table done");
        run(1'b1, 24'h000090, bmd_pkg::BMD_TGT_MOD, 2, 12);
        $display("test module wait done");
        @(posedge sys_clk);
        ext_addr <= 17'h1abcd;
        go <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check(ext_dual_grant, 1'b1);
        check(dual_addr, 17'h1abcd);
        run(1'b0, 24'h000020, bmd_pkg::BMD_TGT_DUAL, 2, 0);
        repeat (2) @(posedge sys_clk);
        #1 check(ext_dual_grant, 1'b1);
        check(dual_addr, 17'h1abcd);
        @(posedge sys_clk);
        go <= 1'b0;
        skip_arb <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check(ext_dual_grant, 1'b0);
        @(posedge sys_clk);
        go <= 1'b0;
        skip_arb <= 1'b0;
        $display("test dual-port arbitration done");
        reset_n <= 1'b0;
        cfg_local_waits <= 4'h3;
        cfg_sync_mode <= 1'b1;
        cfg_modules_present <= 1'b0;
        cfg_boot_size <= 24'h010000;
        cfg_dual_base <= 24'h050000;
        repeat (5) @(posedge sys_clk);
        #1 check({cpu_ready, sel, target, ext_dual_grant}, 11'h000);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        run(1'b0, 24'hff0000, bmd_pkg::BMD_TGT_BOOT, 3, 0);
        run(1'b0, 24'hfc0000, bmd_pkg::BMD_TGT_USER, 3, 0);
        run(1'b0, 24'h040000, bmd_pkg::BMD_TGT_DUAL, 2, 0);
        run(1'b0, 24'h000010, bmd_pkg::BMD_TGT_BUS, 0, 0);
        run(1'b0, 24'h100000, bmd_pkg::BMD_TGT_EXT, 0, 0);
        run(1'b0, 24'he00000, bmd_pkg::BMD_TGT_EXT, 0, 0);
        run(1'b1, 24'h000080, bmd_pkg::BMD_TGT_BUS, 0, 0);
        $display("test alternate straps done");
        final_report();
    end
endmodule // bmd_decoder_bench
bind bmd_decoder bmd_decoder_monitor u_mon (.sys_clk, .reset_n, .cfg_sync_mode, .cpu_req,
    .cpu_ready, .sel, .target, .module_wait_request_n, .ext_dual_req, .ext_bus_owned,
    .ext_dual_addr, .ext_dual_grant, .dual_addr);

// ===== bmd_decoder_monitor.sv
// checker for the memory and i/o decoder ports
`timescale 1ns/100ps
module bmd_decoder_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration and cpu
    input wire logic cfg_sync_mode,
    input wire bmd_pkg::bmd_cpu_req_t cpu_req,
    input wire logic cpu_ready,
    input wire bmd_pkg::bmd_sel_t sel,
    input wire bmd_pkg::bmd_target_t target,
    input wire logic module_wait_request_n,
    // external dual-port side
    input wire logic ext_dual_req,
    input wire logic ext_bus_owned,
    input wire logic [16:0] ext_dual_addr,
    input wire logic ext_dual_grant,
    input wire logic [16:0] dual_addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    grant_owner_a: assert property (ext_dual_grant |-> $past(ext_bus_owned) && $past(ext_dual_req))
        else $error("grant without bus ownership");
    grant_addr_a: assert property (ext_dual_grant |-> dual_addr == $past(ext_dual_addr))
        else $error("dual address not following grant");
    cpu_first_a: assert property (target == bmd_pkg::BMD_TGT_DUAL |-> !ext_dual_grant)
        else $error("external grant during cpu dual cycle");
    dual_waits_a: assert property (target == bmd_pkg::BMD_TGT_NONE ##1 target == bmd_pkg::BMD_TGT_DUAL
        |-> !cpu_ready [*3] ##1 cpu_ready) else $error("dual cycle wait count wrong");
    mod_waits_a: assert property (target == bmd_pkg::BMD_TGT_NONE ##1 target == bmd_pkg::BMD_TGT_MOD
        |-> !cpu_ready [*3]) else $error("module cycle too short");
    ready_pulse_a: assert property (cpu_ready |=> !cpu_ready && target == bmd_pkg::BMD_TGT_NONE)
        else $error("ready longer than one cycle");
    mod_stretch_a: assert property (target == bmd_pkg::BMD_TGT_MOD && !module_wait_request_n [*8]
        |-> !cpu_ready) else $error("ready while module wait held");
    io_window_a: assert property (target == bmd_pkg::BMD_TGT_NONE ##1 target == bmd_pkg::BMD_TGT_MOD
        |-> $past(cpu_req.is_io) && $past(cpu_req.addr[15:0]) >= bmd_pkg::MOD_IO_LO
        && $past(cpu_req.addr[15:0]) <= bmd_pkg::MOD_IO_HI) else $error("module select outside window");
    sync_zero_a: assert property (target == bmd_pkg::BMD_TGT_NONE ##1
        (target == bmd_pkg::BMD_TGT_EXT && cfg_sync_mode) |=> cpu_ready) else $error("sync wait");
    cover property (target == bmd_pkg::BMD_TGT_DUAL && sel.dual_sel);
    cover property (ext_dual_grant);
    cover property (target == bmd_pkg::BMD_TGT_MOD && !module_wait_request_n);
endmodule // bmd_decoder_monitor

// ===== bmd_ext_master.sv
// external bus master model for the dual-port side
`timescale 1ns/100ps
module bmd_ext_master (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bench control
    input wire logic go,
    input wire logic skip_arb,
    input wire logic [16:0] addr,
    // bus side
    output logic ext_bus_owned,
    output logic ext_dual_req,
    output logic [16:0] ext_dual_addr
);
    logic own_q, own_d, req_q, req_d;
    logic [16:0] addr_q, addr_d;
    always_comb
    begin
        own_d = go && !skip_arb;
        req_d = go && (own_q || skip_arb);
        addr_d = req_d ? addr : ~addr_q;
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            own_q <= 1'b0;
            req_q <= 1'b0;
            addr_q <= 17'h00000;
        end
        else
        begin
            own_q <= own_d;
            req_q <= req_d;
            addr_q <= addr_d;
        end
    end
    assign ext_bus_owned = own_q;
    assign ext_dual_req = req_q;
    assign ext_dual_addr = addr_q;
endmodule // bmd_ext_master

// ===== bmd_pkg.sv
// package: address map, wait-state counts and carrier types for the memory/io decoder
package bmd_pkg;

    // cpu address is 24 bits, i/o port address is 16 bits
    localparam int ADDR_W = 24;
    localparam int IO_W = 16;
    localparam int WAIT_W = 4;

    // local memory: 256K bytes total, boot pair top-justified
    localparam logic [23:0] LOCAL_SIZE = 24'h040000;
    localparam logic [23:0] LOCAL_TOP = 24'hffffff;
    localparam logic [23:0] LOCAL_BASE = 24'hfc0000;
    localparam logic [23:0] BOOT_SIZE_RST = 24'h008000;

    // dual-port memory: 128K bytes
    localparam logic [23:0] DUAL_SIZE = 24'h020000;
    localparam logic [23:0] DUAL_BASE_RST = 24'h000000;

    // off-board local extension: 14 megabytes
    localparam logic [23:0] EXT_BASE = 24'h100000;
    localparam logic [23:0] EXT_SIZE = 24'he00000;

    // expansion-module i/o window
    localparam logic [15:0] MOD_IO_LO = 16'h0080;
    localparam logic [15:0] MOD_IO_HI = 16'h00bf;

    // wait states
    localparam logic [3:0] WAIT_DUAL = 4'h2;
    localparam logic [3:0] WAIT_LOCAL_RST = 4'h1;
    localparam logic [3:0] WAIT_MOD_MIN = 4'h2;
    localparam logic [3:0] WAIT_SYNC = 4'h0;
    localparam logic [3:0] WAIT_NONE = 4'h0;

    // synchroniser depth for module wait request
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        BMD_TGT_NONE,
        BMD_TGT_BOOT,
        BMD_TGT_USER,
        BMD_TGT_DUAL,
        BMD_TGT_EXT,
        BMD_TGT_MOD,
        BMD_TGT_BUS
    } bmd_target_t;

    // cpu cycle request
    typedef struct packed {
        logic start;
        logic is_io;
        logic [23:0] addr;
    } bmd_cpu_req_t;

    // chip selects driven to targets
    typedef struct packed {
        logic boot_sel;
        logic user_sel;
        logic dual_sel;
        logic ext_sel;
        logic mod_sel;
        logic bus_sel;
    } bmd_sel_t;

endpackage
